// *** logic/vcc_pkg.sv ***
// vcc_pkg: constants and types for the changeover controller
// assumes: one clock domain, registers reached over axi4-lite
//
// Functional notes
// - factory defaults: black-reference type, auto, primary
// - power-up without faults: auto mode, primary
// - auto mode rejects operator backup requests
// - manual selection applies immediately, ignoring faults
// - auto primary fault: go backup, raise indication
// - primary valid again: show corrected, back primary
// - indication latched until operator confirm press
// - manual primary loss: no switch, still indicate
// - inlet loss indicated, restore shows fixed
// - all power lost: output falls to primary
// - active channel missing signal keeps reporting error
// - commit configuration on menu exit to standby
// - auto table: none P, P B, B P, both B
// - all channels switch together as one
// - show lowest latched channel fault, then next
package vcc_pkg;

	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] VCC_CTRL_OFS = 8'h00;
	localparam logic [7:0] VCC_STATUS_OFS = 8'h04;
	localparam logic [7:0] VCC_CHCNT_OFS = 8'h08;
	localparam logic [7:0] VCC_TYPE_OFS = 8'h0C;
	localparam logic [7:0] VCC_FAULT_OFS = 8'h10;
	localparam logic [7:0] VCC_IRQ_STAT_OFS = 8'h14;
	localparam logic [7:0] VCC_IRQ_EN_OFS = 8'h18;
	localparam logic [7:0] VCC_IRQ_CLR_OFS = 8'h1C;
	localparam logic [7:0] VCC_CMD_OFS = 8'h20;
	localparam logic [7:0] VCC_NVCFG_OFS = 8'h24;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int VCC_CTRL_MANUAL_BIT = 0;
	localparam int VCC_CTRL_SEL_BIT = 1;
	localparam int VCC_CMD_CONFIRM_BIT = 0;
	localparam int VCC_CMD_EXIT_BIT = 1;
	localparam int VCC_TYPE_BITS = 2;
	localparam logic [1:0] VCC_TYPE_NOMEAS = 2'h0;
	localparam logic [1:0] VCC_TYPE_BLACK = 2'h1;
	localparam logic [3:0] VCC_CHCNT_RESET = 4'hC;
	localparam int VCC_IRQ_BITS = 4;
	localparam int VCC_IRQ_PFAULT = 0;
	localparam int VCC_IRQ_BFAULT = 1;
	localparam int VCC_IRQ_INLET = 2;
	localparam int VCC_IRQ_SWITCH = 3;

	// axi responses
	localparam logic [1:0] VCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] VCC_RESP_SLVERR = 2'h2;

	// automatic selection states, gray along idle->fail->recover
	typedef enum logic [1:0] {
		VCC_SEL_PRIMARY = 2'b00,
		VCC_SEL_BACKUP = 2'b01,
		VCC_SEL_RETURN = 2'b11
	} vcc_sel_type;

endpackage : vcc_pkg

// *** logic/vcc_fault_pick.sv ***
// vcc_fault_pick: finds the lowest-numbered latched fault
// assumes: latch vector is already limited to active channels
`timescale 1ns/1ps
module vcc_fault_pick
	import vcc_pkg::*;
#(
	parameter int CHANNELS = 12
) (
	input wire logic [2*CHANNELS-1:0] latch_vec, // bit 2c primary, 2c+1 backup
	output logic any_set, // some latched fault remains
	output logic [4:0] first_idx // index of lowest latched input
);
	initial begin
		if (CHANNELS < 1 || CHANNELS > 16) begin
			$error("vcc_fault_pick: CHANNELS out of range");
		end
	end

	// scan from the top so the lowest set bit wins
	always_comb begin
		any_set = 1'b0;
		first_idx = 5'h00;
		for (int i = 2 * CHANNELS - 1; i >= 0; i--) begin
			if (latch_vec[i]) begin
				any_set = 1'b1;
				first_idx = 5'(i);
			end
		end
	end
endmodule : vcc_fault_pick

// *** logic/vcc_ctrl.sv ***
// vcc_ctrl: changeover controller top, axi4-lite slave plus switch logic
// assumes: fault flags and panel pulses synchronous to CLOCK
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module vcc_ctrl
	import vcc_pkg::*;
#(
	parameter int CHANNELS = 12
) (
	input wire logic CLOCK, // 250 MHz clock
	input wire logic RST, // synchronous reset, active high
	input wire logic CE, // clock enable, freezes all state when low
	input wire logic [CHANNELS-1:0] PRI_FAULT, // primary input fault per channel
	input wire logic [CHANNELS-1:0] BAK_FAULT, // backup input fault per channel
	input wire logic [CHANNELS-1:0] PRI_MISSING, // primary input missing per channel
	input wire logic [CHANNELS-1:0] BAK_MISSING, // backup input missing per channel
	input wire logic [1:0] INLET_OK, // mains inlet present
	input wire logic CONFIRM_PRESS, // panel confirm pulse
	input wire logic MENU_EXIT, // panel returned to standby pulse
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write strobes
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	output logic [1:0] S_AXI_BRESP, // write response
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic SEL_BACKUP, // common switch: high routes to backup
	output logic IND_ON, // fault indication lit
	output logic IND_FIXED, // shown fault has been repaired
	output logic [4:0] IND_INDEX, // shown input, 2c primary 2c+1 backup
	output logic [1:0] INLET_FAULT, // inlet fault indication
	output logic NV_WRITE, // commit configuration to storage pulse
	output logic IRQ // level interrupt
);
	initial begin
		if (CHANNELS < 1 || CHANNELS > 12) begin
			$error("vcc_ctrl: CHANNELS must be 1..12");
		end
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic manual;
		logic man_backup;
		vcc_sel_type sel;
		logic [3:0] chcnt;
		logic [2*CHANNELS-1:0] types;
		logic [2*CHANNELS-1:0] latch;
		logic [4:0] shown;
		logic shown_valid;
		logic [1:0] inlet_fault;
		logic [1:0] inlet_fixed;
		logic [VCC_IRQ_BITS-1:0] irq_stat;
		logic [VCC_IRQ_BITS-1:0] irq_en;
		logic nv_write;
		logic [4+2*CHANNELS-1:0] nv_copy;
	} vcc_state_type;

	vcc_state_type st_reg;
	vcc_state_type st_next;
	logic [CHANNELS-1:0] chan_active;
	logic [2*CHANNELS-1:0] err_now;
	logic any_latched;
	logic [4:0] first_idx;
	logic pri_any;
	logic bak_any;
	logic power_lost;
	logic conf_req;
	logic [2*CHANNELS-1:0] below_first;

	// a channel counts when it lies inside the count and is measured
	function automatic logic ch_live(input logic [3:0] cnt, input logic [1:0] ty, input int c);
		ch_live = (4'(c) < cnt) && (ty != VCC_TYPE_NOMEAS);
	endfunction : ch_live

	// ---------------------------------------------------------------
	// per channel error terms
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			assign chan_active[g] = ch_live(st_reg.chcnt, st_reg.types[2*g +: 2], g);
			// missing signal reports continuously while active
			assign err_now[2*g] = chan_active[g] & (PRI_FAULT[g] | PRI_MISSING[g]);
			assign err_now[2*g+1] = chan_active[g] & (BAK_FAULT[g] | BAK_MISSING[g]);
		end
	endgenerate

	assign pri_any = |(err_now & {CHANNELS{2'b01}});
	assign bak_any = |(err_now & {CHANNELS{2'b10}});
	assign power_lost = (INLET_OK == 2'b00);
	// confirm from the panel or from the command register; the write fires when both halves are held
	assign conf_req = CONFIRM_PRESS | (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid &&
		st_reg.aw_addr == VCC_CMD_OFS && st_reg.w_data[VCC_CMD_CONFIRM_BIT]);
	// latched inputs below the shown one, must stay empty
	assign below_first = st_reg.latch & ~({(2*CHANNELS){1'b1}} << first_idx);

	vcc_fault_pick #(
		.CHANNELS(CHANNELS)
	) u_pick (
		.latch_vec(st_reg.latch),
		.any_set(any_latched),
		.first_idx(first_idx)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic wr_fire;
		logic rd_fire;
		logic [VCC_IRQ_BITS-1:0] ev;
		logic want_backup;
		st_next = st_reg;
		wr_fire = 1'b0;
		rd_fire = 1'b0;
		ev = '0;
		want_backup = 1'b0;
		st_next.nv_write = 1'b0;
		// bus write: address and data in either order
		if (S_AXI_AWVALID && !st_reg.aw_got) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !st_reg.w_got) begin
			st_next.w_got = 1'b1;
			st_next.w_data = S_AXI_WDATA;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			wr_fire = 1'b1;
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = VCC_RESP_OKAY;
		end
		if (st_reg.bvalid && S_AXI_BREADY) begin
			st_next.bvalid = 1'b0;
		end
		if (wr_fire) begin
			case (st_reg.aw_addr)
				VCC_CTRL_OFS: begin
					st_next.manual = st_reg.w_data[VCC_CTRL_MANUAL_BIT];
					st_next.man_backup = st_reg.w_data[VCC_CTRL_SEL_BIT];
				end
				VCC_CHCNT_OFS: begin
					// out of range counts are refused
					if (st_reg.w_data[3:0] >= 4'h1 && 32'(st_reg.w_data[3:0]) <= CHANNELS) begin
						st_next.chcnt = st_reg.w_data[3:0];
					end
				end
				VCC_TYPE_OFS: st_next.types = st_reg.w_data[2*CHANNELS-1:0];
				VCC_IRQ_EN_OFS: st_next.irq_en = st_reg.w_data[VCC_IRQ_BITS-1:0];
				VCC_IRQ_CLR_OFS: st_next.irq_stat = st_reg.irq_stat & ~st_reg.w_data[VCC_IRQ_BITS-1:0];
				VCC_CMD_OFS: begin
				end
				default: st_next.bresp = VCC_RESP_SLVERR;
			endcase
		end
		// bus read, one cycle after the address
		if (S_AXI_ARVALID && !st_reg.rvalid) begin
			rd_fire = 1'b1;
			st_next.rvalid = 1'b1;
			st_next.rresp = VCC_RESP_OKAY;
			case (S_AXI_ARADDR)
				VCC_CTRL_OFS: st_next.rdata = {30'h0, st_reg.man_backup, st_reg.manual};
				VCC_STATUS_OFS: st_next.rdata = {21'h0, st_reg.inlet_fixed, st_reg.inlet_fault,
					st_reg.shown, st_reg.shown_valid, st_reg.sel != VCC_SEL_PRIMARY};
				VCC_CHCNT_OFS: st_next.rdata = {28'h0, st_reg.chcnt};
				VCC_TYPE_OFS: st_next.rdata = 32'(st_reg.types);
				VCC_FAULT_OFS: st_next.rdata = 32'(st_reg.latch);
				VCC_IRQ_STAT_OFS: st_next.rdata = 32'(st_reg.irq_stat);
				VCC_IRQ_EN_OFS: st_next.rdata = 32'(st_reg.irq_en);
				VCC_NVCFG_OFS: st_next.rdata = 32'(st_reg.nv_copy);
				VCC_IRQ_CLR_OFS, VCC_CMD_OFS: st_next.rdata = 32'h00000000;
				default: begin
					st_next.rdata = 32'h00000000;
					st_next.rresp = VCC_RESP_SLVERR;
				end
			endcase
		end
		if (st_reg.rvalid && S_AXI_RREADY) begin
			st_next.rvalid = 1'b0;
		end
		// automatic selection, one common switch for every channel
		want_backup = pri_any;
		case (st_reg.sel)
			VCC_SEL_PRIMARY: if (want_backup) st_next.sel = VCC_SEL_BACKUP;
			VCC_SEL_BACKUP: if (!want_backup) st_next.sel = VCC_SEL_RETURN;
			VCC_SEL_RETURN: st_next.sel = want_backup ? VCC_SEL_BACKUP : VCC_SEL_PRIMARY;
			default: st_next.sel = VCC_SEL_PRIMARY;
		endcase
		if (st_next.sel != st_reg.sel && !st_reg.manual) begin
			ev[VCC_IRQ_SWITCH] = 1'b1;
		end
		// fault latches: set in any mode, cleared by confirm; the shown one also clears on repair while another latch still faults
		if (conf_req) begin
			st_next.latch = '0;
			st_next.inlet_fixed = 2'b00;
		end
		// new error wins over a clear in the same cycle
		st_next.latch = st_next.latch | err_now;
		// repaired latched faults give way to the next one in order
		if (any_latched && (st_reg.latch & ~err_now) != '0) begin
			if (!err_now[first_idx] && ((st_reg.latch & err_now) != '0)) begin
				st_next.latch[first_idx] = 1'b0;
			end
		end
		if (any_latched) begin
			st_next.shown = first_idx;
		end
		// lit follows the latches one edge late, so a confirm darkens it unless a fault relatches
		st_next.shown_valid = any_latched;
		ev[VCC_IRQ_PFAULT] = |(err_now & ~st_reg.latch & {CHANNELS{2'b01}});
		ev[VCC_IRQ_BFAULT] = |(err_now & ~st_reg.latch & {CHANNELS{2'b10}});
		// inlet indication: lit on loss, fixed on restore
		for (int k = 0; k < 2; k++) begin
			if (!INLET_OK[k]) begin
				if (!st_reg.inlet_fault[k]) ev[VCC_IRQ_INLET] = 1'b1;
				st_next.inlet_fault[k] = 1'b1;
				st_next.inlet_fixed[k] = 1'b0;
			end else if (st_reg.inlet_fault[k]) begin
				st_next.inlet_fault[k] = 1'b0;
				st_next.inlet_fixed[k] = 1'b1;
			end
		end
		// configuration commit on exit to standby
		if (MENU_EXIT || (wr_fire && st_reg.aw_addr == VCC_CMD_OFS && st_reg.w_data[VCC_CMD_EXIT_BIT])) begin
			st_next.nv_write = 1'b1;
			st_next.nv_copy = {st_reg.chcnt, st_reg.types};
		end
		// events set over a clear in the same cycle
		st_next.irq_stat = st_next.irq_stat | ev;
		if (rd_fire) begin
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			st_reg <= '0;
			st_reg.manual <= 1'b0;
			st_reg.sel <= VCC_SEL_PRIMARY;
			st_reg.chcnt <= VCC_CHCNT_RESET;
			st_reg.types <= {CHANNELS{VCC_TYPE_BLACK}};
			st_reg.nv_copy <= {VCC_CHCNT_RESET, {CHANNELS{VCC_TYPE_BLACK}}};
		end else if (CE) begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// manual uses the operator choice; auto refuses a forced backup
	// power loss forces primary: the relay rests there unpowered
	assign SEL_BACKUP = !power_lost &&
		(st_reg.manual ? st_reg.man_backup : (st_reg.sel == VCC_SEL_BACKUP));
	assign IND_ON = st_reg.shown_valid | (|st_reg.inlet_fault);
	assign IND_FIXED = st_reg.shown_valid & !err_now[st_reg.shown];
	assign IND_INDEX = st_reg.shown;
	assign INLET_FAULT = st_reg.inlet_fault;
	assign NV_WRITE = st_reg.nv_write;
	assign IRQ = |(st_reg.irq_stat & st_reg.irq_en);
	assign S_AXI_AWREADY = !st_reg.aw_got;
	assign S_AXI_WREADY = !st_reg.w_got;
	assign S_AXI_BVALID = st_reg.bvalid;
	assign S_AXI_BRESP = st_reg.bresp;
	assign S_AXI_ARREADY = !st_reg.rvalid;
	assign S_AXI_RVALID = st_reg.rvalid;
	assign S_AXI_RDATA = st_reg.rdata;
	assign S_AXI_RRESP = st_reg.rresp;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_auto_no_backup: assert property (@(posedge CLOCK) disable iff (RST)
		(!st_reg.manual && !pri_any && st_reg.sel == VCC_SEL_PRIMARY) |-> !SEL_BACKUP)
		else $error("backup selected in auto without primary fault");
	chk_manual_follow: assert property (@(posedge CLOCK) disable iff (RST)
		(st_reg.manual && !power_lost) |-> (SEL_BACKUP == st_reg.man_backup))
		else $error("manual selection not followed");
	chk_fault_switch: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && !st_reg.manual && pri_any && !power_lost && st_reg.sel == VCC_SEL_PRIMARY)
		|=> (st_reg.sel == VCC_SEL_BACKUP))
		else $error("no changeover on primary fault");
	chk_fault_latch: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && |err_now) |=> any_latched)
		else $error("fault not latched");
	chk_latch_hold: assert property (@(posedge CLOCK) disable iff (RST)
		!CE |=> $stable(st_reg.latch))
		else $error("latch changed while frozen");
	chk_latch_keep: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && any_latched && !conf_req) |=> any_latched)
		else $error("latched fault lost without confirm");
	chk_inlet_ind: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && !INLET_OK[0]) |=> INLET_FAULT[0])
		else $error("inlet fault not shown");
	chk_power_primary: assert property (@(posedge CLOCK) disable iff (RST)
		power_lost |-> !SEL_BACKUP)
		else $error("backup selected with no power");
	chk_nv_commit: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && MENU_EXIT) |=> (NV_WRITE && st_reg.nv_copy[2*CHANNELS-1:0] == $past(st_reg.types)))
		else $error("configuration not committed on exit");
	chk_first_lowest: assert property (@(posedge CLOCK) disable iff (RST)
		any_latched |-> (st_reg.latch[first_idx] && below_first == '0))
		else $error("shown fault is not the lowest latched");
	chk_return_primary: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && st_reg.sel == VCC_SEL_RETURN && !pri_any) |=> (st_reg.sel == VCC_SEL_PRIMARY))
		else $error("no return to primary after repair");
	chk_backup_only: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && !st_reg.manual && !pri_any && bak_any && st_reg.sel == VCC_SEL_PRIMARY)
		|=> (st_reg.sel == VCC_SEL_PRIMARY))
		else $error("backup only fault moved the switch");
	chk_missing_err: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && |(chan_active & PRI_MISSING)) |=> ((st_reg.latch & {CHANNELS{2'b01}}) != '0))
		else $error("missing input not latched as fault");
	chk_inlet_fixed: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && INLET_OK[0] && INLET_FAULT[0]) |=> (!INLET_FAULT[0] && st_reg.inlet_fixed[0]))
		else $error("inlet repair not shown");
	chk_reset_primary: assert property (@(posedge CLOCK)
		RST |=> (st_reg.sel == VCC_SEL_PRIMARY && !st_reg.manual && !SEL_BACKUP))
		else $error("reset left backup or manual selected");
endmodule : vcc_ctrl

// *** tb/vcc_panel_model.sv ***
// vcc_panel_model: fault detectors and operator panel facing the controller
// assumes: the bench sets wanted levels, the model launches them after each edge
`timescale 1ns/1ps
module vcc_panel_model
	import vcc_pkg::*;
(
	input wire logic clock, // controller clock
	input wire logic [11:0] want_pri, // wanted primary faults
	input wire logic [11:0] want_bak, // wanted backup faults
	input wire logic [11:0] want_miss, // wanted missing primaries
	input wire logic [1:0] want_inlet, // wanted inlet power
	input wire logic want_conf, // confirm press request
	input wire logic want_exit, // menu exit request
	output logic [11:0] pri_fault = 12'h000, // primary fault flags
	output logic [11:0] bak_fault = 12'h000, // backup fault flags
	output logic [11:0] pri_miss = 12'h000, // primary missing flags
	output logic [1:0] inlet_ok = 2'h3, // inlet power flags
	output logic confirm = 1'b0, // confirm pulse
	output logic menu_exit = 1'b0 // standby return pulse
);
	// -------------------------------------------
	// detector and panel outputs
	// -------------------------------------------
	// one registered flag per input, so no flag moves between edges
	always @(posedge clock) begin
		pri_fault <= want_pri;
		bak_fault <= want_bak;
		pri_miss <= want_miss;
		inlet_ok <= want_inlet;
		// a press lasts as many cycles as the bench asks, normally one
		confirm <= want_conf;
		menu_exit <= want_exit;
	end
endmodule : vcc_panel_model

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for the changeover controller
// assumes: one 250 MHz clock, panel model on the far side, axi4-lite master here
`timescale 1ns/1ps
module tb_top
	import vcc_pkg::*;
;
	// -------------------------------------------
	// signals and reference state
	// -------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd, rdata;
	logic [11:0] w_pri = 12'h000, w_bak = 12'h000, w_miss = 12'h000, act, pf, bf, pm;
	logic [1:0] w_inl = 2'h3, inl, resp, bresp, rresp, inlet_fault;
	logic w_conf = 1'b0, w_exit = 1'b0, conf, mexit, ce = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, sel, ind_on, ind_fixed, nv_write, irq;
	logic [4:0] ind_index;
	logic [23:0] lat;
	bit man, msel, skip_ind;
	int err_count = 0, comparisons = 0, seed = 32'hF869CC54, lo, hi, n;
	logic [7:0] rst_ofs [4] = '{VCC_CTRL_OFS, VCC_CHCNT_OFS, VCC_TYPE_OFS, VCC_IRQ_STAT_OFS};
	logic [31:0] rst_val [4] = '{32'h0, 32'hC, 32'h00555555, 32'h0};

	always #2 clk = ~clk;

	vcc_panel_model panel (.clock(clk), .want_pri(w_pri), .want_bak(w_bak), .want_miss(w_miss),
		.want_inlet(w_inl), .want_conf(w_conf), .want_exit(w_exit), .pri_fault(pf), .bak_fault(bf),
		.pri_miss(pm), .inlet_ok(inl), .confirm(conf), .menu_exit(mexit));

	vcc_ctrl #(.CHANNELS(12)) DUT (.CLOCK(clk), .RST(rst), .CE(ce), .PRI_FAULT(pf), .BAK_FAULT(bf),
		.PRI_MISSING(pm), .BAK_MISSING(12'h000), .INLET_OK(inl), .CONFIRM_PRESS(conf), .MENU_EXIT(mexit),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .SEL_BACKUP(sel), .IND_ON(ind_on), .IND_FIXED(ind_fixed),
		.IND_INDEX(ind_index), .INLET_FAULT(inlet_fault), .NV_WRITE(nv_write), .IRQ(irq));

	// -------------------------------------------
	// verdict and compare
	// -------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// -------------------------------------------
	// axi4-lite master
	// -------------------------------------------
	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		resp = bresp;
		if (n >= 50)
			err_count++;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
		if (n >= 50)
			err_count++;
	endtask : axi_rd

	// -------------------------------------------
	// reference model
	// -------------------------------------------
	// power loss outranks manual choice, manual outranks faults
	function automatic logic model_sel();
		if (w_inl == 2'b00)
			return 1'b0;
		if (man)
			return msel;
		return |((w_pri | w_miss) & act);
	endfunction : model_sel

	// shown input is the lowest latched one still faulting; index unchecked once all clean
	task automatic check_all();
		logic [23:0] cur;
		int f;
		f = 99;
		for (int c = 0; c < 12; c++)
			cur[2*c +: 2] = {w_bak[c], w_pri[c] | w_miss[c]} & {2{act[c]}};
		for (int i = 23; i >= 0; i--)
			if (lat[i] && cur[i])
				f = i;
		check("select", model_sel(), sel);
		if (!skip_ind) begin
			check("lit", |lat, ind_on);
			if (|lat)
				check("fixed", f == 99, ind_fixed);
			if (f < 99)
				check("index", f, ind_index);
		end
	endtask : check_all

	task automatic apply(input logic [11:0] p, b, m, input logic [1:0] i);
		w_pri <= p;
		w_bak <= b;
		w_miss <= m;
		w_inl <= i;
		repeat (6) @(posedge clk);
		for (int c = 0; c < 12; c++)
			if (act[c])
				lat[2*c +: 2] = lat[2*c +: 2] | {b[c], p[c] | m[c]};
		check_all();
	endtask : apply

	// confirm drops every latch; faults still present latch again at once
	task automatic press_confirm();
		w_conf <= 1'b1;
		@(posedge clk);
		w_conf <= 1'b0;
		repeat (4) @(posedge clk);
		lat = '0;
		apply(w_pri, w_bak, w_miss, w_inl);
	endtask : press_confirm

	task automatic set_mode(input bit m, input bit s);
		axi_wr(VCC_CTRL_OFS, {30'h0, s, m});
		man = m;
		msel = s;
		apply(w_pri, w_bak, w_miss, w_inl);
	endtask : set_mode

	task automatic do_reset();
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		man = 0;
		msel = 0;
		act = 12'hFFF;
		lat = '0;
		skip_ind = 0;
	endtask : do_reset

	// -------------------------------------------
	// scenarios
	// -------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end

	initial begin
		do_reset();
		apply(0, 0, 0, 3);
		for (int k = 0; k < 4; k++) begin
			axi_rd(rst_ofs[k]);
			check("reset value", rst_val[k], rd);
		end
		axi_rd(8'h28);
		check("unmapped", VCC_RESP_SLVERR, resp);
		set_mode(0, 1);
		set_mode(1, 1);
		apply(12'h001, 0, 0, 3);
		press_confirm();
		set_mode(1, 0);
		apply(12'h002, 0, 0, 3);
		apply(0, 0, 0, 3);
		press_confirm();
		set_mode(0, 0);
		lo = $unsigned($random(seed)) % 6;
		hi = 6 + $unsigned($random(seed)) % 6;
		apply(12'h001 << lo, 0, 0, 3);
		apply(0, 0, 0, 3);
		press_confirm();
		apply(0, 12'h010, 0, 3);
		apply(12'h010, 12'h010, 0, 3);
		apply(0, 0, 0, 3);
		press_confirm();
		apply((12'h001 << lo) | (12'h001 << hi), 0, 0, 3);
		apply(12'h001 << hi, 0, 0, 3);
		apply(0, 0, 0, 3);
		press_confirm();
		// clock enable low: a primary fault must not move the frozen switch
		ce <= 1'b0;
		w_pri <= 12'h001;
		repeat (6) @(posedge clk);
		check("frozen select", 0, sel);
		ce <= 1'b1;
		apply(12'h001, 0, 0, 3);
		apply(0, 0, 0, 3);
		press_confirm();
		// interrupt: stale status cleared first, then only new primary fault enabled
		axi_wr(VCC_IRQ_CLR_OFS, 32'hF);
		axi_wr(VCC_IRQ_EN_OFS, 32'h1);
		check("irq idle", 0, irq);
		apply(12'h001 << hi, 0, 0, 3);
		check("irq raised", 1, irq);
		apply(0, 0, 0, 3);
		axi_wr(VCC_IRQ_CLR_OFS, 32'h1);
		repeat (2) @(posedge clk);
		check("irq cleared", 0, irq);
		axi_rd(VCC_IRQ_STAT_OFS);
		check("irq status", 0, rd[VCC_IRQ_PFAULT]);
		press_confirm();
		axi_wr(VCC_CHCNT_OFS, 32'hD);
		check("count resp", VCC_RESP_OKAY, resp);
		axi_rd(VCC_CHCNT_OFS);
		check("count", 32'hC, rd);
		axi_wr(VCC_CHCNT_OFS, 32'h2);
		axi_wr(VCC_TYPE_OFS, 32'h5);
		act = 12'h003;
		apply(0, 0, 12'h002, 3);
		apply(0, 0, 0, 3);
		press_confirm();
		apply(12'h020, 0, 0, 3);
		axi_wr(VCC_TYPE_OFS, 32'h1);
		act = 12'h001;
		apply(0, 0, 12'h002, 3);
		w_exit <= 1'b1;
		@(posedge clk);
		w_exit <= 1'b0;
		n = 0;
		while (nv_write !== 1'b1 && n < 8) begin
			@(posedge clk);
			n++;
		end
		check("commit", 1, nv_write);
		axi_rd(VCC_NVCFG_OFS);
		check("commit copy", 32'h02000001, rd);
		apply(0, 0, 0, 3);
		set_mode(1, 1);
		skip_ind = 1;
		apply(0, 0, 0, 2'b10);
		check("inlet lost", 2'b01, inlet_fault);
		apply(0, 0, 0, 3);
		axi_rd(VCC_STATUS_OFS);
		check("inlet fixed", 1, rd[9]);
		apply(0, 0, 0, 2'b00);
		apply(0, 0, 0, 3);
		do_reset();
		apply(0, 0, 0, 3);
		complete_run();
	end
endmodule : tb_top
